// File: rtl/pnc_gateway.sv
`timescale 1ns/10ps
`default_nettype none
module pnc_gateway
  import pnc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic irq_in,
  input wire pnc_gw_cfg_s cfg,
  input wire logic clr,
  output logic pending
);
  // ----------------------------------------
  // Gateway pending bit
  // ----------------------------------------
  logic prev;
  logic next_prev;
  logic held;
  logic next_held;
  logic lvl;

  always_comb begin
    lvl = irq_in ^ cfg.active_low;
    next_prev = lvl;
    next_held = held;
    // Edge wins over a clear in the same cycle
    if (clr) begin
      next_held = 1'b0;
    end
    if (lvl && !prev) begin
      next_held = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev <= 1'b0;
      held <= 1'b0;
    end else begin
      prev <= next_prev;
      held <= next_held;
    end
  end

  assign pending = cfg.type_edge ? held : lvl;

  edge_hold_a: assert property (@(posedge clk)
    disable iff (rst) (cfg.type_edge && lvl && !prev) |=> held)
    else $error("edge not captured");
  clear_drop_a: assert property (@(posedge clk)
    disable iff (rst) (clr && !(lvl && !prev)) |=> !held)
    else $error("clear did not drop pending");
endmodule
`default_nettype wire

// File: rtl/pnc_nest_regs.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Claim capture loads priority of captured source
// - Priority CSR paths invert in reverse order
// - Interrupt only above both thresholds
// - Current priority firmware-written only, resets zero
// - Config bit 1 selects level or edge
// - Config bit 0 selects polarity
// - Config register at 0x4000 plus 4S
// - Clear write at 0x5000 plus 4S drops pending in edge mode; level-mode pending follows the input
// - Clear register accepts any write, reads zero
// - Gateway registers idempotent 32-bit words
// - CSR numbers decoded as documented
// - Claim trigger captures ID and priority together
// - Priorities at or below threshold are masked
module pnc_nest_regs
  import pnc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reverse_order,
  input wire pnc_csr_req_s csr_req,
  output logic [31:0] csr_rdata,
  input wire pnc_mem_req_s mem_req,
  output logic [31:0] mem_rdata,
  input wire logic [NSRC-1:1] ext_irq,
  input wire logic [IDW-1:0] win_id,
  input wire logic [PRIW-1:0] win_pri,
  output logic [NSRC-1:1] gw_pending,
  output logic ext_int
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Reverse order is handled by flipping at the core boundary only
  function automatic logic [3:0] prio_map(input logic [3:0] v,
                                          input logic rev);
    prio_map = rev ? ~v : v;
  endfunction

  function automatic logic [8:0] gw_index(input logic [15:0] a,
                                          input logic [15:0] base);
    gw_index = {((a & GW_WIN_MASK) == base), a[9:2]};
  endfunction

  // ----------------------------------------
  // CSR state
  // ----------------------------------------
  logic [21:0] vt_base;
  logic [21:0] next_vt_base;
  logic [3:0] thresh;
  logic [3:0] next_thresh;
  logic [3:0] claim_pri;
  logic [3:0] next_claim_pri;
  logic [3:0] cur_pri;
  logic [3:0] next_cur_pri;
  logic [7:0] claim_id;
  logic [7:0] next_claim_id;
  logic [3:0] wr4;

  always_comb begin
    next_vt_base = vt_base;
    next_thresh = thresh;
    next_claim_pri = claim_pri;
    next_cur_pri = cur_pri;
    next_claim_id = claim_id;
    wr4 = prio_map(csr_req.wdata[3:0], reverse_order);
    if (csr_req.we) begin
      if (csr_req.addr == CSR_VEC_TABLE) begin
        next_vt_base = csr_req.wdata[31:VT_BASE_LSB];
      end else if (csr_req.addr == CSR_THRESH) begin
        next_thresh = wr4;
      end else if (csr_req.addr == CSR_CLAIM_TRIG) begin
        next_claim_id = win_id;
        next_claim_pri = win_pri;
      end else if (csr_req.addr == CSR_CLAIM_PRI) begin
        next_claim_pri = wr4;
      end else if (csr_req.addr == CSR_CUR_PRI) begin
        next_cur_pri = wr4;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      vt_base <= VT_RESET;
      thresh <= PRI_RESET;
      claim_pri <= PRI_RESET;
      cur_pri <= PRI_RESET;
      claim_id <= 8'h00;
    end else begin
      vt_base <= next_vt_base;
      thresh <= next_thresh;
      claim_pri <= next_claim_pri;
      cur_pri <= next_cur_pri;
      claim_id <= next_claim_id;
    end
  end

  always_comb begin
    csr_rdata = ZERO_WORD;
    if (csr_req.addr == CSR_VEC_TABLE) begin
      csr_rdata = {vt_base, 10'h000};
    end else if (csr_req.addr == CSR_THRESH) begin
      csr_rdata = {28'h000_0000, prio_map(thresh, reverse_order)};
    end else if (csr_req.addr == CSR_CLAIM_PRI) begin
      csr_rdata = {28'h000_0000, prio_map(claim_pri, reverse_order)};
    end else if (csr_req.addr == CSR_CUR_PRI) begin
      csr_rdata = {28'h000_0000, prio_map(cur_pri, reverse_order)};
    end else if (csr_req.addr == CSR_HANDLER_PTR) begin
      csr_rdata = {vt_base, claim_id, 2'b00};
    end
  end

  // ----------------------------------------
  // Notification
  // ----------------------------------------
  // Stored values are in standard order, so each mask is one plain compare
  assign ext_int = (win_pri > thresh) && (win_pri > cur_pri);

  // ----------------------------------------
  // Gateway registers
  // ----------------------------------------
  logic [8:0] cfg_idx;
  logic [8:0] clr_idx;
  pnc_gw_cfg_s gw_cfg [NSRC];
  pnc_gw_cfg_s next_gw_cfg [NSRC];

  assign cfg_idx = gw_index(mem_req.addr, GW_CFG_BASE);
  assign clr_idx = gw_index(mem_req.addr, GW_CLR_BASE);

  always_comb begin
    for (int s = 0; s < NSRC; s++) begin
      next_gw_cfg[s] = gw_cfg[s];
    end
    // Source 0 has no gateway; its word stays reserved
    if (mem_req.we && cfg_idx[8] && cfg_idx[7:0] != 8'h00) begin
      next_gw_cfg[cfg_idx[7:0]] = mem_req.wdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    for (int s = 0; s < NSRC; s++) begin
      if (rst) begin
        gw_cfg[s] <= GW_CFG_RESET;
      end else begin
        gw_cfg[s] <= next_gw_cfg[s];
      end
    end
  end

  always_comb begin
    mem_rdata = ZERO_WORD;
    if (cfg_idx[8] && cfg_idx[7:0] != 8'h00) begin
      mem_rdata = {30'h0000_0000, gw_cfg[cfg_idx[7:0]]};
    end
  end

  genvar g;
  generate
    for (g = 1; g < NSRC; g++) begin : gen_gw
      pnc_gateway u_gw (
        .clk(clk),
        .rst(rst),
        .irq_in(ext_irq[g]),
        .cfg(gw_cfg[g]),
        .clr(mem_req.we && clr_idx == {1'b1, 8'(g)}),
        .pending(gw_pending[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence claim_write;
    csr_req.we && csr_req.addr == CSR_CLAIM_TRIG;
  endsequence

  sequence thresh_write;
    csr_req.we && csr_req.addr == CSR_THRESH;
  endsequence

  sequence cur_write;
    csr_req.we && csr_req.addr == CSR_CUR_PRI;
  endsequence

  claim_capture_a: assert property (@(posedge clk)
    disable iff (rst) claim_write |=> claim_pri == $past(win_pri))
    else $error("claimed priority not captured");
  claim_id_a: assert property (@(posedge clk)
    disable iff (rst) claim_write |=> claim_id == $past(win_id))
    else $error("claim id not captured");
  cur_hold_a: assert property (@(posedge clk)
    disable iff (rst) !(csr_req.we && csr_req.addr == CSR_CUR_PRI)
      |=> $stable(cur_pri))
    else $error("current priority changed without write");
  inv_read_a: assert property (@(posedge clk)
    disable iff (rst) (csr_req.addr == CSR_CUR_PRI) |->
      csr_rdata[3:0] == (reverse_order ? ~cur_pri : cur_pri))
    else $error("current priority read path wrong");
  ext_gate_a: assert property (@(posedge clk)
    disable iff (rst) ext_int |-> (win_pri > thresh && win_pri > cur_pri))
    else $error("interrupt above mask");
  mask_all_a: assert property (@(posedge clk)
    disable iff (rst) (thresh == 4'hF) |-> !ext_int)
    else $error("threshold 15 did not mask");
  clr_read_a: assert property (@(posedge clk)
    disable iff (rst) clr_idx[8] |-> mem_rdata == ZERO_WORD)
    else $error("clear register read nonzero");
  cfg_write_a: assert property (@(posedge clk)
    disable iff (rst) (mem_req.we && cfg_idx[8] && cfg_idx[7:0] != 8'h00)
      |=> gw_cfg[$past(cfg_idx[7:0])] == $past(mem_req.wdata[1:0]))
    else $error("gateway config not written");
  thresh_load_a: assert property (@(posedge clk)
    disable iff (rst) thresh_write |=> thresh == $past(reverse_order ?
      ~csr_req.wdata[3:0] : csr_req.wdata[3:0]))
    else $error("threshold not loaded");
  cur_load_a: assert property (@(posedge clk)
    disable iff (rst) cur_write |=> cur_pri == $past(reverse_order ?
      ~csr_req.wdata[3:0] : csr_req.wdata[3:0]))
    else $error("current priority not loaded");
  trig_read_a: assert property (@(posedge clk)
    disable iff (rst) (csr_req.addr == CSR_CLAIM_TRIG) |->
      csr_rdata == ZERO_WORD)
    else $error("claim trigger read nonzero");
  hp_format_a: assert property (@(posedge clk)
    disable iff (rst) (csr_req.addr == CSR_HANDLER_PTR) |->
      csr_rdata[31:VT_BASE_LSB] == vt_base
      && csr_rdata[VT_BASE_LSB-1:HP_ID_LSB] == claim_id
      && csr_rdata[1:0] == 2'b00)
    else $error("handler pointer layout wrong");
  upper_zero_a: assert property (@(posedge clk)
    disable iff (rst) (csr_req.addr == CSR_CUR_PRI) |->
      csr_rdata[31:PRIW] == 28'h000_0000)
    else $error("current priority upper bits nonzero");
  src0_cfg_a: assert property (@(posedge clk)
    disable iff (rst) (cfg_idx[8] && cfg_idx[7:0] == 8'h00) |->
      mem_rdata == ZERO_WORD)
    else $error("source 0 config word not reserved");
endmodule
`default_nettype wire

// File: shared/pnc_pkg.sv
package pnc_pkg;
  // ----------------------------------------
  // CSR numbers
  // ----------------------------------------
  localparam logic [11:0] CSR_VEC_TABLE = 12'h0BC8;
  localparam logic [11:0] CSR_THRESH = 12'h0BC9;
  localparam logic [11:0] CSR_CLAIM_TRIG = 12'h0BCA;
  localparam logic [11:0] CSR_CLAIM_PRI = 12'h0BCB;
  localparam logic [11:0] CSR_CUR_PRI = 12'h0BCC;
  localparam logic [11:0] CSR_HANDLER_PTR = 12'h0FC8;
  // ----------------------------------------
  // Memory-mapped gateway offsets
  // ----------------------------------------
  localparam logic [15:0] GW_CFG_BASE = 16'h4000;
  localparam logic [15:0] GW_CLR_BASE = 16'h5000;
  // Bits 15:10 and 1:0 take part, so no offset aliases onto a source
  localparam logic [15:0] GW_WIN_MASK = 16'hFC03;
  localparam int NSRC = 256;
  localparam int IDW = 8;
  localparam int PRIW = 4;
  // ----------------------------------------
  // Field positions and resets
  // ----------------------------------------
  localparam int GW_POL_BIT = 0;
  localparam int GW_TYPE_BIT = 1;
  localparam int VT_BASE_LSB = 10;
  localparam int HP_ID_LSB = 2;
  localparam logic [3:0] PRI_RESET = 4'h0;
  localparam logic [1:0] GW_CFG_RESET = 2'h0;
  localparam logic [21:0] VT_RESET = 22'h00_0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef struct packed {
    logic we;
    logic re;
    logic [11:0] addr;
    logic [31:0] wdata;
  } pnc_csr_req_s;

  typedef struct packed {
    logic we;
    logic re;
    logic [15:0] addr;
    logic [31:0] wdata;
  } pnc_mem_req_s;

  typedef struct packed {
    logic type_edge;
    logic active_low;
  } pnc_gw_cfg_s;
endpackage

// File: test/pnc_src_model.sv
`timescale 1ns/10ps
`default_nettype none
module pnc_src_model
  import pnc_pkg::*;
(
  input wire logic clk,
  output logic [NSRC-1:1] ext_irq,
  output logic [IDW-1:0] win_id,
  output logic [PRIW-1:0] win_pri
);
  initial begin
    ext_irq = '0;
    win_id = '0;
    win_pri = '0;
  end
  // Changes land just after an edge, like a synchronous source
  task automatic drive(input int s, input logic v);
    @(posedge clk);
    ext_irq[s] <= v;
  endtask
  // Winner of the outside arbitration, standard order
  task automatic set_win(input logic [7:0] id, input logic [3:0] pri);
    @(posedge clk);
    win_id <= id;
    win_pri <= pri;
  endtask
endmodule
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench
  import pnc_pkg::*;
;
  logic clk, rst, reverse_order, ext_int;
  pnc_csr_req_s csr_req;
  pnc_mem_req_s mem_req;
  logic [31:0] csr_rdata, mem_rdata;
  logic [NSRC-1:1] ext_irq, gw_pending;
  logic [IDW-1:0] win_id;
  logic [PRIW-1:0] win_pri;
  int miscompares, check_count;

  pnc_nest_regs u_pnc_nest_regs (.clk, .rst, .reverse_order, .csr_req,
    .csr_rdata, .mem_req, .mem_rdata, .ext_irq, .win_id, .win_pri,
    .gw_pending, .ext_int);
  pnc_src_model u_pnc_src_model (.clk, .ext_irq, .win_id, .win_pri);

  // ----------------------------------------
  // Bus helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic csr_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    csr_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    csr_req.we <= 1'b0;
  endtask
  task automatic csr_chk(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    csr_req.addr <= a;
    #1 chk(csr_rdata, e);
  endtask
  task automatic mem_wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    mem_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    mem_req.we <= 1'b0;
  endtask
  task automatic mem_chk(input logic [15:0] a, input logic [31:0] e);
    @(posedge clk);
    mem_req.addr <= a;
    #1 chk(mem_rdata, e);
  endtask
  task automatic win_chk(input logic [3:0] p, input logic e);
    u_pnc_src_model.set_win(8'h01, p);
    #1 chk(32'(ext_int), 32'(e));
  endtask
  task automatic pend_chk(input int s, input logic e);
    #1 chk(32'(gw_pending[s]), 32'(e));
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_claim;
    csr_chk(CSR_CUR_PRI, ZERO_WORD);
    mem_chk(16'h4004, ZERO_WORD);
    u_pnc_src_model.set_win(8'h05, 4'h9);
    csr_wr(CSR_VEC_TABLE, 32'hFFFF_FFFF);
    csr_wr(CSR_CLAIM_TRIG, ZERO_WORD);
    // Winner moves on; the snapshot must not follow it
    u_pnc_src_model.set_win(8'h06, 4'h2);
    csr_chk(CSR_CLAIM_PRI, 32'h0000_0009);
    csr_chk(CSR_HANDLER_PTR, 32'hFFFF_FC14);
    csr_wr(CSR_HANDLER_PTR, ZERO_WORD);
    csr_chk(CSR_HANDLER_PTR, 32'hFFFF_FC14);
    csr_chk(CSR_CLAIM_TRIG, ZERO_WORD);
    csr_chk(CSR_VEC_TABLE, 32'hFFFF_FC00);
    csr_chk(CSR_CUR_PRI, ZERO_WORD);
    $display("test claim done");
  endtask
  task automatic t_nest;
    csr_wr(CSR_THRESH, 32'h0000_0003);
    win_chk(4'h4, 1'b1);
    win_chk(4'h3, 1'b0);
    csr_wr(CSR_CUR_PRI, 32'hFFFF_FFF9);
    csr_chk(CSR_CUR_PRI, 32'h0000_0009);
    win_chk(4'h9, 1'b0);
    win_chk(4'hA, 1'b1);
    $display("test nest done");
  endtask
  task automatic t_reverse;
    @(posedge clk);
    reverse_order <= 1'b1;
    csr_chk(CSR_CLAIM_PRI, 32'h0000_0006);
    csr_chk(CSR_CUR_PRI, 32'h0000_0006);
    csr_wr(CSR_THRESH, 32'h0000_000F);
    csr_wr(CSR_CUR_PRI, 32'h0000_000F);
    win_chk(4'h0, 1'b0);
    win_chk(4'h1, 1'b1);
    csr_chk(CSR_THRESH, 32'h0000_000F);
    csr_wr(CSR_THRESH, ZERO_WORD);
    win_chk(4'hF, 1'b0);
    csr_wr(CSR_CLAIM_PRI, 32'h0000_0004);
    @(posedge clk);
    reverse_order <= 1'b0;
    csr_chk(CSR_CLAIM_PRI, 32'h0000_000B);
    $display("test reverse done");
  endtask
  task automatic t_gateway;
    u_pnc_src_model.drive(7, 1'b1);
    pend_chk(7, 1'b1);
    mem_wr(16'h501C, ZERO_WORD);
    pend_chk(7, 1'b1);
    mem_wr(16'h401C, 32'hFFFF_FFFD);
    mem_chk(16'h401C, 32'h0000_0001);
    pend_chk(7, 1'b0);
    mem_wr(16'h43FC, 32'h0000_0002);
    u_pnc_src_model.drive(255, 1'b1);
    u_pnc_src_model.drive(255, 1'b0);
    pend_chk(255, 1'b1);
    mem_wr(16'h53FC, ZERO_WORD);
    mem_wr(16'h53FC, ZERO_WORD);
    pend_chk(255, 1'b0);
    mem_chk(16'h53FC, ZERO_WORD);
    mem_chk(16'h43FC, 32'h0000_0002);
    u_pnc_src_model.drive(1, 1'b1);
    mem_wr(16'h4004, 32'h0000_0003);
    mem_wr(16'h5004, 32'hFFFF_FFFF);
    pend_chk(1, 1'b0);
    u_pnc_src_model.drive(1, 1'b0);
    // Falling input is caught at the next edge
    @(posedge clk);
    pend_chk(1, 1'b1);
    mem_wr(GW_CFG_BASE, 32'hFFFF_FFFF);
    mem_chk(GW_CFG_BASE, ZERO_WORD);
    $display("test gateway done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    reverse_order = 1'b0;
    csr_req = '0;
    mem_req = '0;
    miscompares = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_claim;
    t_nest;
    t_reverse;
    t_gateway;
    report_and_stop;
  end
  // Whole run needs well under 300 cycles
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    report_and_stop;
  end
endmodule
`default_nettype wire
